// >>> pcm_pkg.sv
package pcm_pkg;

  localparam int unsigned CLK_FREQ_HZ = 250_000_000;
  // slow clock arrives as a pin level, nominally 32.768 kHz
  localparam int unsigned SLOW_CLOCK_HZ = 32768;
  localparam logic [2:0] SLOW_DIV_LAST = 3'h7;

  localparam int unsigned PERIPH_COUNT = 30;
  localparam logic [29:0] PERIPH_IMPL_MASK = 30'h3fff_fffc;

  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_PCLK_EN = 8'h04;
  localparam logic [7:0] OFS_SYSCLK_EN = 8'h08;
  localparam logic [7:0] OFS_PROG_SEL = 8'h0c;
  localparam logic [7:0] OFS_OSC_CFG = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h68;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h6c;
  localparam logic [7:0] OFS_COUNT = 8'h70;

  localparam int unsigned SYS_PROC_BIT = 0;
  localparam int unsigned SYS_UDEV_BIT = 1;
  localparam int unsigned SYS_UHOST_BIT = 2;
  localparam logic USB_DEV_PRESENT = 1'b1;
  localparam logic USB_HOST_PRESENT = 1'b0;

  localparam int unsigned OSC_EN_BIT = 0;
  localparam int unsigned OSC_CNT_LSB = 8;
  localparam int unsigned OSC_CNT_W = 8;
  localparam int unsigned ST_STABLE_BIT = 0;
  localparam logic [7:0] OSC_CNT_RST = 8'h00;

  // one-hot operating modes
  typedef enum logic [3:0] {
    PCM_NORMAL = 4'b0001,
    PCM_IDLE = 4'b0010,
    PCM_SLOW = 4'b0100,
    PCM_STANDBY = 4'b1000
  } pcm_mode_t;

  localparam logic [1:0] MODE_CODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_CODE_IDLE = 2'h1;
  localparam logic [1:0] MODE_CODE_SLOW = 2'h2;
  localparam logic [1:0] MODE_CODE_STANDBY = 2'h3;

  typedef struct packed {
    logic proc_gate;
    logic slow_select;
    logic osc_on;
    logic pll_on;
  } pcm_clk_ctl_t;

endpackage : pcm_pkg

// >>> pcm_top.sv
module pcm_top
  import pcm_pkg::*;
#(
  parameter logic USB_DIV2 = 1'b0
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic slow_clock_i,
  input wire logic wake_irq_i,
  output logic proc_clk_en_o,
  output logic [29:0] periph_clk_en_o,
  output logic dma_clk_en_o,
  output logic usb_dev_clk_en_o,
  output logic usb_host_clk_en_o,
  output logic usb_div2_en_o,
  output logic [3:0] prog_clk_en_o,
  output logic [7:0] prog_clk_sel_o,
  output logic slow_select_o,
  output logic main_osc_enable_o,
  output logic pll_enable_o,
  output logic irq_o
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  logic wr_acc;
  logic rd_acc;
  assign wr_acc = psel_i & penable_i & pwrite_i;
  assign rd_acc = psel_i & penable_i & ~pwrite_i;

  // slow clock only sampled here, never gated
  // slow clock pin synchroniser, then edge detect between the second and third stages
  logic slow_s1_r;
  logic slow_s2_r;
  logic slow_s3_r;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      slow_s1_r <= 1'b0;
      slow_s2_r <= 1'b0;
      slow_s3_r <= 1'b0;
    end else begin
      slow_s1_r <= slow_clock_i;
      slow_s2_r <= slow_s1_r;
      slow_s3_r <= slow_s2_r;
    end
  end
  logic slow_rise;
  assign slow_rise = slow_s2_r & ~slow_s3_r;

  logic wake_s1_r;
  logic wake_s2_r;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
    end else begin
      wake_s1_r <= wake_irq_i;
      wake_s2_r <= wake_s1_r;
    end
  end

  // operating mode
  pcm_mode_t mode_r;
  pcm_mode_t mode_nxt;
  always_comb begin
    mode_nxt = mode_r;
    if (wr_acc && hit(paddr_i, OFS_MODE)) begin
      unique case (pwdata_i[1:0])
        MODE_CODE_NORMAL: mode_nxt = PCM_NORMAL;
        MODE_CODE_IDLE: mode_nxt = PCM_IDLE;
        MODE_CODE_SLOW: mode_nxt = PCM_SLOW;
        MODE_CODE_STANDBY: mode_nxt = PCM_STANDBY;
      endcase
    end else if (wake_s2_r) begin
      unique case (mode_r)
        PCM_IDLE: mode_nxt = PCM_NORMAL;
        PCM_STANDBY: mode_nxt = PCM_SLOW;
        PCM_NORMAL, PCM_SLOW: mode_nxt = mode_r;
        default: mode_nxt = PCM_SLOW;
      endcase
    end
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_r <= PCM_SLOW;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  logic [1:0] mode_code;
  always_comb begin
    unique case (mode_r)
      PCM_NORMAL: mode_code = MODE_CODE_NORMAL;
      PCM_IDLE: mode_code = MODE_CODE_IDLE;
      PCM_SLOW: mode_code = MODE_CODE_SLOW;
      PCM_STANDBY: mode_code = MODE_CODE_STANDBY;
      default: mode_code = MODE_CODE_SLOW;
    endcase
  end

  // gate registers
  logic [29:0] pclk_r;
  logic [2:0] sysclk_r;
  logic [3:0] prog_en_r;
  logic [7:0] prog_sel_r;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pclk_r <= '0;
      sysclk_r <= 3'h1;
      prog_en_r <= 4'h0;
      prog_sel_r <= 8'h00;
    end else begin
      if (wr_acc && hit(paddr_i, OFS_PCLK_EN)) begin
        pclk_r <= pwdata_i[29:0] & PERIPH_IMPL_MASK;
      end
      if (wr_acc && hit(paddr_i, OFS_SYSCLK_EN)) begin
        sysclk_r <= {pwdata_i[SYS_UHOST_BIT] & USB_HOST_PRESENT,
                     pwdata_i[SYS_UDEV_BIT] & USB_DEV_PRESENT,
                     pwdata_i[SYS_PROC_BIT]};
      end
      if (wr_acc && hit(paddr_i, OFS_PROG_SEL)) begin
        prog_en_r <= pwdata_i[3:0];
        prog_sel_r <= pwdata_i[15:8];
      end
    end
  end

  // oscillator control and startup countdown
  logic osc_en_r;
  logic [7:0] osc_cnt_r;
  logic [7:0] count_r;
  logic [2:0] div8_r;
  logic counting_r;
  logic stable_r;
  logic [0:0] mask_r;
  logic osc_wr;
  assign osc_wr = wr_acc && hit(paddr_i, OFS_OSC_CFG);
  logic tick8;
  assign tick8 = slow_rise && (div8_r == SLOW_DIV_LAST);
  logic done_evt;
  assign done_evt = counting_r && tick8 && (count_r == 8'h00);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_en_r <= 1'b0;
      osc_cnt_r <= OSC_CNT_RST;
      count_r <= 8'h00;
      div8_r <= 3'h0;
      counting_r <= 1'b0;
    end else begin
      if (slow_rise) begin
        div8_r <= div8_r + 3'h1;
      end
      if (osc_wr) begin
        osc_en_r <= pwdata_i[OSC_EN_BIT];
        osc_cnt_r <= pwdata_i[OSC_CNT_LSB +: OSC_CNT_W];
        if (pwdata_i[OSC_EN_BIT] && !osc_en_r) begin
          count_r <= pwdata_i[OSC_CNT_LSB +: OSC_CNT_W];
          counting_r <= 1'b1;
          div8_r <= 3'h0;
        end else if (!pwdata_i[OSC_EN_BIT]) begin
          counting_r <= 1'b0;
        end
      end else if (counting_r && tick8) begin
        if (count_r == 8'h00) begin
          counting_r <= 1'b0;
        end else begin
          count_r <= count_r - 8'h01;
        end
      end
    end
  end

  // stable flag and write-one-to-clear status
  logic w1c_stable;
  assign w1c_stable = wr_acc && hit(paddr_i, OFS_STATUS) && pwdata_i[ST_STABLE_BIT];
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stable_r <= 1'b0;
    end else if (osc_wr && (!pwdata_i[OSC_EN_BIT] || !osc_en_r)) begin
      // disable or fresh enable clears stable
      stable_r <= 1'b0;
    end else if (done_evt) begin
      // countdown done, set wins over clear
      stable_r <= 1'b1;
    end else if (w1c_stable) begin
      stable_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_r <= 1'b0;
    end else if (wr_acc && hit(paddr_i, OFS_IRQ_MASK)) begin
      mask_r <= pwdata_i[ST_STABLE_BIT];
    end
  end

  // clock control outputs, all registered
  pcm_clk_ctl_t ctl;
  always_comb begin
    ctl.proc_gate = sysclk_r[SYS_PROC_BIT] && (mode_nxt == PCM_NORMAL || mode_nxt == PCM_SLOW);
    ctl.slow_select = (mode_nxt == PCM_SLOW) || (mode_nxt == PCM_STANDBY);
    ctl.osc_on = osc_en_r && !ctl.slow_select;
    ctl.pll_on = !ctl.slow_select && stable_r;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      proc_clk_en_o <= 1'b0;
      periph_clk_en_o <= '0;
      dma_clk_en_o <= 1'b1;
      usb_dev_clk_en_o <= 1'b0;
      usb_host_clk_en_o <= 1'b0;
      usb_div2_en_o <= 1'b0;
      prog_clk_en_o <= 4'h0;
      prog_clk_sel_o <= 8'h00;
      slow_select_o <= 1'b1;
      main_osc_enable_o <= 1'b0;
      pll_enable_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      proc_clk_en_o <= ctl.proc_gate;
      periph_clk_en_o <= pclk_r;
      // DMA clock kept in every mode
      dma_clk_en_o <= 1'b1;
      usb_dev_clk_en_o <= sysclk_r[SYS_UDEV_BIT];
      usb_host_clk_en_o <= sysclk_r[SYS_UHOST_BIT];
      usb_div2_en_o <= USB_DIV2;
      prog_clk_en_o <= prog_en_r;
      prog_clk_sel_o <= prog_sel_r;
      slow_select_o <= ctl.slow_select;
      main_osc_enable_o <= ctl.osc_on;
      pll_enable_o <= ctl.pll_on;
      irq_o <= stable_r & mask_r[0];
    end
  end

  // apb read, single access cycle
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      if (psel_i && !penable_i && !pwrite_i) begin
        unique case (paddr_i)
          OFS_MODE: prdata_o <= {30'h0, mode_code};
          OFS_PCLK_EN: prdata_o <= {2'h0, pclk_r};
          OFS_SYSCLK_EN: prdata_o <= {29'h0, sysclk_r};
          OFS_PROG_SEL: prdata_o <= {16'h0, prog_sel_r, 4'h0, prog_en_r};
          OFS_OSC_CFG: prdata_o <= {16'h0, osc_cnt_r, 7'h0, osc_en_r};
          OFS_STATUS: prdata_o <= {31'h0, stable_r};
          OFS_IRQ_MASK: prdata_o <= {31'h0, mask_r};
          OFS_COUNT: prdata_o <= {23'h0, counting_r, count_r};
          default: prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  logic unused_rd;
  assign unused_rd = rd_acc;

  reset_mode_a: assert property (@(posedge clock_i) $rose(rst_b_i) |-> mode_r == PCM_SLOW)
    else $error("mode not slow after reset");
  idle_gate_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    mode_r == PCM_IDLE |-> !proc_clk_en_o)
    else $error("processor clock running in idle");
  standby_clk_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    mode_r == PCM_STANDBY |-> slow_select_o && !proc_clk_en_o)
    else $error("standby clocks wrong");
  slow_osc_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    mode_r == PCM_SLOW |-> !main_osc_enable_o && !pll_enable_o)
    else $error("oscillator on in slow mode");
  periph_mask_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (pclk_r & ~PERIPH_IMPL_MASK) == '0)
    else $error("unimplemented gate set");
  disable_clr_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    osc_wr && !pwdata_i[OSC_EN_BIT] |=> !stable_r)
    else $error("stable kept after disable");
  done_set_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    done_evt && !osc_wr |=> stable_r ##1 irq_o == $past(mask_r[0]))
    else $error("stable not set at zero");
  irq_follow_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ##1 irq_o == $past(stable_r & mask_r[0]))
    else $error("irq mismatch");
  abort_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !osc_en_r |-> !counting_r)
    else $error("countdown runs while disabled");

endmodule : pcm_top

// >>> pcm_sys_model.sv
module pcm_sys_model #(
  parameter int SLOW_HALF = 4
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic proc_clk_en_i,
  input wire logic wake_req_i,
  output logic slow_clock_o,
  output logic wake_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int half_cnt;
  // free running timebase
  // scaled far above 32.768 kHz to keep countdowns short
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      half_cnt <= 0;
      slow_clock_o <= 1'b0;
    end else if (half_cnt == SLOW_HALF - 1) begin
      half_cnt <= 0;
      slow_clock_o <= ~slow_clock_o;
    end else begin
      half_cnt <= half_cnt + 1;
    end
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_irq_o <= 1'b0;
    end else begin
      wake_irq_o <= wake_req_i & ~proc_clk_en_i;
    end
  end
endmodule : pcm_sys_model

// >>> pcm_top_tb.sv
module pcm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcm_pkg::*;
  logic clk, rst_b, psel, pen, pwr, slow, wake, wake_req, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, proc_en, dma_en, udev, uhost, div2, slow_sel, osc_en, pll_en, irq;
  logic [29:0] periph;
  logic [3:0] prog_en;
  logic [7:0] prog_sel;
  int fails, tests_run, cyc, t0;
  pcm_top DUT (.clock_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .slow_clock_i(slow), .wake_irq_i(wake),
    .proc_clk_en_o(proc_en), .periph_clk_en_o(periph), .dma_clk_en_o(dma_en),
    .usb_dev_clk_en_o(udev), .usb_host_clk_en_o(uhost), .usb_div2_en_o(div2),
    .prog_clk_en_o(prog_en), .prog_clk_sel_o(prog_sel), .slow_select_o(slow_sel),
    .main_osc_enable_o(osc_en), .pll_enable_o(pll_en), .irq_o(irq));
  pcm_sys_model sys (.clock_i(clk), .rst_b_i(rst_b), .proc_clk_en_i(proc_en),
    .wake_req_i(wake_req), .slow_clock_o(slow), .wake_irq_o(wake));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic report_and_stop;
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no limit of its own: only the run timeout ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd
  // gate outputs follow a committed write one edge later, mode-driven outputs on the commit edge itself
  task automatic settle;
    @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic wake_up;
    int n;
    @(posedge clk);
    wake_req <= 1'b1;
    n = 0;
    while (proc_en !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    wake_req <= 1'b0;
    chk(proc_en, 1'b1);
  endtask : wake_up
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    chk(irq, 1'b1);
  endtask : wait_irq
  initial begin
    {psel, pen, pwr, wake_req, rst_b} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fails = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    rd(OFS_MODE, {30'h0, MODE_CODE_SLOW});
    chk(slow_sel, 1'b1);
    chk(proc_en, 1'b1);
    chk(pll_en, 1'b0);
    chk(osc_en, 1'b0);
    chk(dma_en, 1'b1);
    chk(div2, 1'b0);
    rd(8'h40, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0);
    chk(pslverr, 1'b0);
    for (int i = 0; i < 30; i++) begin
      wr(OFS_PCLK_EN, 32'h1 << i);
      settle();
      chk(periph, PERIPH_IMPL_MASK & (30'h1 << i));
    end
    wr(OFS_PCLK_EN, 32'hffff_ffff);
    rd(OFS_PCLK_EN, {2'b00, PERIPH_IMPL_MASK});
    wr(OFS_SYSCLK_EN, 32'h0000_0007);
    rd(OFS_SYSCLK_EN, {29'h0, USB_HOST_PRESENT, USB_DEV_PRESENT, 1'b1});
    settle();
    chk(uhost, USB_HOST_PRESENT);
    chk(udev, USB_DEV_PRESENT);
    wr(OFS_PROG_SEL, 32'hffff_ffff);
    rd(OFS_PROG_SEL, 32'h0000_ff0f);
    wr(OFS_PROG_SEL, 32'h0000_9c05);
    settle();
    chk({prog_sel, prog_en}, 12'h9c5);
    wr(OFS_MODE, {30'h0, MODE_CODE_NORMAL});
    settle();
    chk({slow_sel, proc_en}, 2'b01);
    wr(OFS_MODE, {30'h0, MODE_CODE_IDLE});
    settle();
    chk({proc_en, dma_en, periph}, {2'b01, PERIPH_IMPL_MASK});
    wake_up();
    rd(OFS_MODE, {30'h0, MODE_CODE_NORMAL});
    wr(OFS_MODE, {30'h0, MODE_CODE_STANDBY});
    settle();
    chk({slow_sel, proc_en}, 2'b10);
    wake_up();
    rd(OFS_MODE, {30'h0, MODE_CODE_SLOW});
    wr(OFS_MODE, {30'h0, MODE_CODE_NORMAL});
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_OSC_CFG, 32'h0000_0201);
    t0 = cyc;
    rd(OFS_STATUS, 32'h0);
    chk(osc_en, 1'b1);
    wait_irq();
    // (2+1) steps of 8 slow periods, a slow period being 8 clocks in the model
    chk((cyc - t0 >= 176) && (cyc - t0 <= 208), 1'b1);
    rd(OFS_STATUS, 32'h1);
    chk(pll_en, 1'b1);
    wr(OFS_MODE, {30'h0, MODE_CODE_SLOW});
    settle();
    chk({osc_en, pll_en, slow_sel}, 3'b001);
    wr(OFS_MODE, {30'h0, MODE_CODE_NORMAL});
    wr(OFS_IRQ_MASK, 32'h0);
    settle();
    chk(irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h1);
    settle();
    chk(irq, 1'b1);
    wr(OFS_OSC_CFG, 32'h0);
    rd(OFS_STATUS, 32'h0);
    settle();
    chk({osc_en, irq}, 2'b00);
    wr(OFS_OSC_CFG, 32'h0000_0001);
    wait_irq();
    wr(OFS_STATUS, 32'h1);
    settle();
    chk(irq, 1'b0);
    wr(OFS_OSC_CFG, 32'h0);
    wr(OFS_OSC_CFG, 32'h0000_ff01);
    rd(OFS_OSC_CFG, 32'h0000_ff01);
    wr(OFS_OSC_CFG, 32'h0);
    wr(OFS_OSC_CFG, 32'h0000_0401);
    repeat (100) @(posedge clk);
    wr(OFS_OSC_CFG, 32'h0);
    repeat (600) @(posedge clk);
    rd(OFS_STATUS, 32'h0);
    chk(irq, 1'b0);
    report_and_stop();
  end
endmodule : pcm_top_tb
